// ### clk_gen_ctl.sv
// Clock generator control: PLL and stop control, self-clock sequencing and periodic tick control
`include "clk_gen_cfg.svh"

module clk_gen_ctl
    import clk_gen_pkg::*;
#(
    parameter int ADDR_W       = 8,
    parameter int BIN_LOG_BASE = `TICK_BIN_LOG_BASE,
    parameter int DEC_UNIT     = `TICK_DEC_UNIT
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              specialMode,
    input  wire logic              pllLock,
    input  wire logic              crystalFail,
    input  wire logic              fullStopWake,
    input  wire logic              qualityOk,
    input  wire logic              pseudoStop,
    input  wire logic              waitMode,
    output fm_amp_t                freqModAmplitude,
    output logic                   fmStrobe,
    output logic                   pllClockSelect,
    output logic                   selfClockActive,
    output logic                   oscEnable,
    output logic                   clockMonitorEnable,
    output logic                   qualityCheckRun,
    output logic                   clockMonitorReset,
    output logic                   watchdogRun,
    output logic                   watchdogInit,
    output logic                   tickRun,
    output logic                   tickEvent
);

    // Reset images, so single fields are picked by index rather than shifted
    localparam logic [7:0] PLL_STOP_RST_V  = `PLL_STOP_RST;
    localparam logic [7:0] CLOCK_SEL_RST_V = `CLOCK_SEL_RST;

    logic [5:0]     awIdx;
    logic           awPend;
    logic [7:0]     wByte;
    logic           wLane0;
    logic           wPend;
    logic           doWrite;
    logic           wePllStop;
    logic           weTick;
    logic           weClkSel;
    logic           weStatus;
    logic           mapped;
    logic [5:0]     arIdx;
    logic [7:0]     readByte;
    logic           readHit;
    logic           fastWakeupEnable;
    logic           tickPseudoStopRun;
    logic           watchdogPseudoStopRun;
    logic           selfClockFallbackEnable;
    logic           fallbackWritten;
    logic [7:0]     periodicTickControl;
    logic           tickWaitStop;
    logic           watchdogWaitStop;
    logic           selfClockChangeFlag;
    logic [3:0]     fmCnt;
    logic           tickReinit;
    logic           tickIdle;
    selfclk_state_t state;
    selfclk_state_t next_state;

    // Write channel acceptance; both halves held until the pair completes
    assign awready = !awPend && !bvalid;
    assign wready  = !wPend && !bvalid;
    assign doWrite = awPend && wPend && !bvalid;

    always_ff @(posedge clk) begin
        if (srst) begin
            awPend <= 1'b0;
            awIdx  <= 6'h00;
        end else if (awvalid && awready) begin
            awPend <= 1'b1;
            awIdx  <= awaddr[7:2];
        end else if (doWrite) begin
            awPend <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wPend  <= 1'b0;
            wByte  <= 8'h00;
            wLane0 <= 1'b0;
        end else if (wvalid && wready) begin
            wPend  <= 1'b1;
            wByte  <= wdata[7:0];
            wLane0 <= wstrb[0];
        end else if (doWrite) begin
            wPend <= 1'b0;
        end
    end

    // Address decode of the stored write
    always_comb begin
        wePllStop = 1'b0;
        weTick    = 1'b0;
        weClkSel  = 1'b0;
        weStatus  = 1'b0;
        mapped    = 1'b1;
        if (awIdx == `IDX_PLL_STOP) begin
            wePllStop = doWrite && wLane0;
        end else if (awIdx == `IDX_TICK_CTL) begin
            weTick = doWrite && wLane0;
        end else if (awIdx == `IDX_CLOCK_SEL) begin
            weClkSel = doWrite && wLane0;
        end else if (awIdx == `IDX_STATUS) begin
            weStatus = doWrite && wLane0;
        end else begin
            mapped = 1'b0;
        end
    end

    // Write response; unmapped words answer SLVERR
    always_ff @(posedge clk) begin
        if (srst) begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read decode; narrow registers sit in the low byte
    assign arIdx   = araddr[7:2];
    assign arready = !rvalid;
    always_comb begin
        readByte = 8'h00;
        readHit  = 1'b1;
        if (arIdx == `IDX_PLL_STOP) begin
            readByte = {2'b00, freqModAmplitude, fastWakeupEnable, tickPseudoStopRun,
                        watchdogPseudoStopRun, selfClockFallbackEnable};
        end else if (arIdx == `IDX_TICK_CTL) begin
            readByte = periodicTickControl;
        end else if (arIdx == `IDX_CLOCK_SEL) begin
            readByte = {pllClockSelect, 5'b00000, tickWaitStop, watchdogWaitStop};
        end else if (arIdx == `IDX_STATUS) begin
            readByte = {5'b00000, pllLock, selfClockChangeFlag, selfClockActive};
        end else begin
            readHit = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, readByte};
            rresp  <= readHit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Amplitude field, frozen while the PLL drives the system
    always_ff @(posedge clk) begin
        if (srst) begin
            freqModAmplitude <= fm_amp_t'(PLL_STOP_RST_V[`FM_MSB:`FM_LSB]);
        end else if (wePllStop && !pllClockSelect) begin
            freqModAmplitude <= fm_amp_t'(wByte[`FM_MSB:`FM_LSB]);
        end
    end

    // Pseudo-stop run bits and fast wake-up, all writable anytime
    always_ff @(posedge clk) begin
        if (srst) begin
            fastWakeupEnable      <= PLL_STOP_RST_V[`FAST_WAKEUP_ENABLE_BIT];
            tickPseudoStopRun     <= PLL_STOP_RST_V[`PRE_BIT];
            watchdogPseudoStopRun <= PLL_STOP_RST_V[`PCE_BIT];
        end else if (wePllStop) begin
            fastWakeupEnable      <= wByte[`FAST_WAKEUP_ENABLE_BIT];
            tickPseudoStopRun     <= wByte[`PRE_BIT];
            watchdogPseudoStopRun <= wByte[`PCE_BIT];
        end
    end

    // Fallback enable: one shot in normal modes, free in special modes; no clear while self-clocked
    always_ff @(posedge clk) begin
        if (srst) begin
            selfClockFallbackEnable <= PLL_STOP_RST_V[`SELF_CLOCK_FALLBACK_ENABLE_BIT];
            fallbackWritten         <= 1'b0;
        end else if (wePllStop) begin
            fallbackWritten <= 1'b1;
            if (specialMode || !fallbackWritten) begin
                if (wByte[`SELF_CLOCK_FALLBACK_ENABLE_BIT] || !selfClockActive) begin
                    selfClockFallbackEnable <= wByte[`SELF_CLOCK_FALLBACK_ENABLE_BIT];
                end
            end
        end
    end

    // tick control, anytime; write restarts the counter
    always_ff @(posedge clk) begin
        if (srst) begin
            periodicTickControl <= `TICK_CTL_RST;
        end else if (weTick) begin
            periodicTickControl <= wByte;
        end
    end

    // PLL select; hardware clear on self-clock entry beats software
    always_ff @(posedge clk) begin
        if (srst) begin
            pllClockSelect   <= CLOCK_SEL_RST_V[`PLL_CLOCK_SELECT_BIT];
            tickWaitStop     <= CLOCK_SEL_RST_V[`TICK_WAIT_BIT];
            watchdogWaitStop <= CLOCK_SEL_RST_V[`WDOG_WAIT_BIT];
        end else begin
            if (next_state != SC_NORMAL) begin
                pllClockSelect <= 1'b0;
            end else if (weClkSel && (pllLock || !wByte[`PLL_CLOCK_SELECT_BIT])) begin
                pllClockSelect <= wByte[`PLL_CLOCK_SELECT_BIT];
            end
            if (weClkSel) begin
                tickWaitStop     <= wByte[`TICK_WAIT_BIT];
                watchdogWaitStop <= wByte[`WDOG_WAIT_BIT];
            end
        end
    end

    // Self-clock sequencer
    always_comb begin
        next_state = state;
        case (state)
            SC_NORMAL: begin
                // failure falls back only if enabled
                if (crystalFail && selfClockFallbackEnable) begin
                    next_state = SC_SELF;
                end else if (fullStopWake && fastWakeupEnable && selfClockFallbackEnable) begin
                    next_state = SC_FAST;
                end
            end
            SC_SELF: begin
                if (qualityOk) begin
                    next_state = SC_NORMAL;
                end
            end
            SC_FAST: begin
                if (!fastWakeupEnable) begin
                    next_state = SC_CHECK;
                end
            end
            SC_CHECK: begin
                if (qualityOk) begin
                    next_state = SC_NORMAL;
                end
            end
            default: next_state = SC_NORMAL;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= SC_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // oscillator and monitor off during fast wake
    assign selfClockActive    = (state != SC_NORMAL);
    assign oscEnable          = (state != SC_FAST);
    assign clockMonitorEnable = (state != SC_FAST);
    assign qualityCheckRun    = (state == SC_CHECK) || (state == SC_SELF);

    // Change flag: a hardware set wins over a same-cycle write-one clear
    always_ff @(posedge clk) begin
        if (srst) begin
            selfClockChangeFlag <= 1'b0;
        // fast wake entry leaves flag alone
        end else if ((state == SC_NORMAL && next_state == SC_SELF) ||
                     (state != SC_NORMAL && next_state == SC_NORMAL)) begin
            selfClockChangeFlag <= 1'b1;
        end else if (weStatus && wByte[`STAT_SELF_CLOCK_CHANGE_FLAG_BIT]) begin
            selfClockChangeFlag <= 1'b0;
        end
    end

    // monitor reset pulse when fallback disabled
    always_ff @(posedge clk) begin
        if (srst) begin
            clockMonitorReset <= 1'b0;
        end else begin
            clockMonitorReset <= (state == SC_NORMAL) && crystalFail && !selfClockFallbackEnable;
        end
    end

    // modulation strobe every sixteen reference cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            fmCnt    <= 4'h0;
            fmStrobe <= 1'b0;
        end else begin
            fmCnt    <= (5'(fmCnt) == `FM_RATE_DIV - 5'h01) ? 4'h0 : fmCnt + 4'h1;
            fmStrobe <= (5'(fmCnt) == `FM_RATE_DIV - 5'h01) && (freqModAmplitude != FM_OFF);
        end
    end

    // watchdog holds in pseudo stop when bit clear; wait stop reinits
    assign watchdogRun  = !(pseudoStop && !watchdogPseudoStopRun) && !(waitMode && watchdogWaitStop);
    assign watchdogInit = waitMode && watchdogWaitStop;

    // tick runs in pseudo stop only when bit set
    assign tickRun    = !(pseudoStop && !tickPseudoStopRun) && !(waitMode && tickWaitStop);
    assign tickReinit = weTick || (waitMode && tickWaitStop);

    // divider counts clk, the oscillator clock
    tick_divider #(
        .BIN_LOG_BASE(BIN_LOG_BASE),
        .DEC_UNIT    (DEC_UNIT)
    ) u_tick (
        .clk       (clk),
        .srst      (srst),
        .reinit    (tickReinit),
        .run       (tickRun),
        .decimalSel(periodicTickControl[`TICK_DEC_BIT]),
        .rateSel   (periodicTickControl[`TICK_RATE_MSB:`TICK_RATE_LSB]),
        .modulusSel(periodicTickControl[`TICK_MOD_MSB:`TICK_MOD_LSB]),
        .tickEvent (tickEvent),
        .tickIdle  (tickIdle)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_fastEntry;
        state == SC_NORMAL && !crystalFail && fullStopWake && fastWakeupEnable && selfClockFallbackEnable;
    endsequence

    sequence s_fastLeave;
        state == SC_FAST && !fastWakeupEnable;
    endsequence

    property p_fmFrozen;
        wePllStop && pllClockSelect |=> $stable(freqModAmplitude);
    endproperty
    a_fmFrozen: assert property (p_fmFrozen) else $error("amplitude changed while PLL selected");

    property p_fmRate;
        fmStrobe |=> !fmStrobe [*8];
    endproperty
    a_fmRate: assert property (p_fmRate) else $error("modulation strobe too frequent");

    property p_fastNoFlag;
        s_fastEntry and !selfClockChangeFlag |=> state == SC_FAST && !selfClockChangeFlag;
    endproperty
    a_fastNoFlag: assert property (p_fastNoFlag) else $error("fast wake set change flag");

    property p_fastHold;
        state == SC_FAST && fastWakeupEnable |=> state == SC_FAST && !oscEnable && !clockMonitorEnable;
    endproperty
    a_fastHold: assert property (p_fastHold) else $error("fast wake left early");

    property p_fastExit;
        s_fastLeave |=> state == SC_CHECK && oscEnable && clockMonitorEnable && qualityCheckRun;
    endproperty
    a_fastExit: assert property (p_fastExit) else $error("check not started");

    property p_checkPass;
        state == SC_CHECK && qualityOk |=> state == SC_NORMAL && selfClockChangeFlag;
    endproperty
    a_checkPass: assert property (p_checkPass) else $error("passed check did not switch");

    property p_fallbackKept;
        selfClockActive && selfClockFallbackEnable |=> selfClockFallbackEnable;
    endproperty
    a_fallbackKept: assert property (p_fallbackKept) else $error("fallback cleared while self-clocked");

    property p_failReset;
        state == SC_NORMAL && crystalFail && !selfClockFallbackEnable |=> clockMonitorReset && state == SC_NORMAL;
    endproperty
    a_failReset: assert property (p_failReset) else $error("missing monitor reset");

    property p_failSelf;
        state == SC_NORMAL && crystalFail && selfClockFallbackEnable |=> state == SC_SELF && !clockMonitorReset;
    endproperty
    a_failSelf: assert property (p_failSelf) else $error("missing self-clock entry");

    property p_pllUnlocked;
        !pllLock && !pllClockSelect |=> !pllClockSelect;
    endproperty
    a_pllUnlocked: assert property (p_pllUnlocked) else $error("PLL selected while unlocked");

    property p_onceOnly;
        fallbackWritten && !specialMode && wePllStop |=> $stable(selfClockFallbackEnable);
    endproperty
    a_onceOnly: assert property (p_onceOnly) else $error("second fallback write accepted");

    property p_idleQuiet;
        tickIdle |=> !tickEvent;
    endproperty
    a_idleQuiet: assert property (p_idleQuiet) else $error("tick event while idle");

endmodule // clk_gen_ctl

// ### clk_gen_cfg.svh
// Register indices, field positions, reset values and timing counts of the clock control block
`ifndef CLK_GEN_CFG_SVH
`define CLK_GEN_CFG_SVH

// Word indices; byte address is four times the index
`define IDX_PLL_STOP      6'h06
`define IDX_TICK_CTL      6'h07
`define IDX_CLOCK_SEL     6'h08
`define IDX_STATUS        6'h09

// pll_and_stop_control fields
`define FM_MSB            5
`define FM_LSB            4
`define FAST_WAKEUP_ENABLE_BIT        3
`define PRE_BIT           2
`define PCE_BIT           1
`define SELF_CLOCK_FALLBACK_ENABLE_BIT          0

// periodic_tick_control fields
`define TICK_DEC_BIT      7
`define TICK_RATE_MSB     6
`define TICK_RATE_LSB     4
`define TICK_MOD_MSB      3
`define TICK_MOD_LSB      0

// clock_select fields
`define PLL_CLOCK_SELECT_BIT        7
`define TICK_WAIT_BIT     1
`define WDOG_WAIT_BIT     0

// status fields
`define STAT_SCM_BIT      0
`define STAT_SELF_CLOCK_CHANGE_FLAG_BIT    1
`define STAT_LOCK_BIT     2

// Reset values
`define PLL_STOP_RST      8'h01
`define TICK_CTL_RST      8'h00
`define CLOCK_SEL_RST     8'h00

// Frequency modulation rate divider (reference clock cycles)
`define FM_RATE_DIV       5'h10

// Tick prescaler bases
`define TICK_BIN_LOG_BASE 10
`define TICK_DEC_UNIT     1000

// AXI response codes
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### clk_gen_pkg.sv
// Types shared by the clock control block
package clk_gen_pkg;

    // Self-clock sequencer states, one-hot
    typedef enum logic [3:0] {
        SC_NORMAL = 4'b0001,
        SC_SELF   = 4'b0010,
        SC_FAST   = 4'b0100,
        SC_CHECK  = 4'b1000
    } selfclk_state_t;

    // Frequency modulation amplitude codes
    typedef enum logic [1:0] {
        FM_OFF  = 2'h0,
        FM_1PCT = 2'h1,
        FM_2PCT = 2'h2,
        FM_4PCT = 2'h3
    } fm_amp_t;

endpackage

// ### tick_divider.sv
// Periodic tick prescaler and modulus divider on the oscillator clock
`include "clk_gen_cfg.svh"

module tick_divider #(
    parameter int BIN_LOG_BASE = `TICK_BIN_LOG_BASE,
    parameter int DEC_UNIT     = `TICK_DEC_UNIT
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       reinit,
    input  wire logic       run,
    input  wire logic       decimalSel,
    input  wire logic [2:0] rateSel,
    input  wire logic [3:0] modulusSel,
    output logic            tickEvent,
    output logic            tickIdle
);

    logic [19:0] preLimit;
    logic [19:0] preCnt;
    logic [3:0]  modCnt;
    logic        off;
    int          mult;

    assign off      = !decimalSel && (rateSel == 3'h0);
    assign tickIdle = off;

    always_comb begin
        mult = 1;
        case (rateSel)
            3'h0: mult = 1;
            3'h1: mult = 2;
            3'h2: mult = 5;
            3'h3: mult = 10;
            3'h4: mult = 20;
            3'h5: mult = 50;
            3'h6: mult = 100;
            default: mult = 200;
        endcase
        if (decimalSel) begin
            preLimit = 20'(DEC_UNIT * mult);
        end else if (off) begin
            preLimit = 20'h00001;
        end else begin
            preLimit = 20'(32'h1 << (BIN_LOG_BASE + int'(rateSel) - 1));
        end
    end

    // Counters; >= compare keeps a shrunk setting from running away
    always_ff @(posedge clk) begin
        if (srst || reinit || off) begin
            preCnt    <= 20'h00000;
            modCnt    <= 4'h0;
            tickEvent <= 1'b0;
        end else if (run) begin
            tickEvent <= 1'b0;
            if (preCnt >= preLimit - 20'h00001) begin
                preCnt <= 20'h00000;
                // modulus divides by code plus one
                if (modCnt >= modulusSel) begin
                    modCnt    <= 4'h0;
                    tickEvent <= 1'b1;
                end else begin
                    modCnt <= modCnt + 4'h1;
                end
            end else begin
                preCnt <= preCnt + 20'h00001;
            end
        end else begin
            tickEvent <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_offSilent;
        off |=> !tickEvent;
    endproperty
    a_offSilent: assert property (p_offSilent) else $error("tick event while off");

    property p_holdStill;
        !run && !reinit && !off |=> $stable(preCnt) && $stable(modCnt);
    endproperty
    a_holdStill: assert property (p_holdStill) else $error("tick divider moved while stopped");

endmodule // tick_divider

// ### tb_top.sv
// Self-checking bench for the clock control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'h0, srst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic        bready = 1'h1, rready = 1'h1, awready, wready, bvalid, arready, rvalid, tickEvent;
    logic        specialMode = 1'h0, pllLock = 1'h0, crystalFail = 1'h0, fullStopWake = 1'h0;
    logic        qualityOk = 1'h0, pseudoStop = 1'h0, waitMode = 1'h0, pllClockSelect, selfClockActive;
    logic        fmStrobe, oscEnable, clockMonitorEnable, qualityCheckRun, clockMonitorReset;
    logic        watchdogRun, watchdogInit, tickRun;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp, r;
    clk_gen_pkg::fm_amp_t freqModAmplitude;
    logic [7:0]  tc [5] = '{8'h12, 8'h70, 8'h81, 8'hB0, 8'h05};
    int          tp [5] = '{6, 128, 4, 20, 300};
    int          n_errors = 0, n_checks = 0, c;
    // Small prescale bases keep tick periods short
    clk_gen_ctl #(.BIN_LOG_BASE(1), .DEC_UNIT(2)) i_clk_gen_ctl (.clk, .srst, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .specialMode, .pllLock, .crystalFail, .fullStopWake, .qualityOk,
        .pseudoStop, .waitMode, .freqModAmplitude, .fmStrobe, .pllClockSelect, .selfClockActive,
        .oscEnable, .clockMonitorEnable, .qualityCheckRun, .clockMonitorReset, .watchdogRun,
        .watchdogInit, .tickRun, .tickEvent);
    // 50 MHz clock
    always #10 clk = ~clk;
    task automatic results;
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 50) begin
            n_errors++;
            results();
        end
    endtask
    // Ready sampled at negedge, as it only moves on the rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        int n;
        logic ta, tw, tb;
        n = 0;
        awaddr <= a;
        wdata <= {24'h000000, v};
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            n++;
        end while (tb !== 1'h1 && n < 50);
        tmo(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        logic ta, tb;
        n = 0;
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(negedge clk);
            ta = arvalid & arready;
            tb = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'h0;
            n++;
        end while (tb !== 1'h1 && n < 50);
        tmo(n);
    endtask
    // Gap between two tick events (w 0) or modulation strobes (w 1); 300 means none seen
    task automatic per(input logic w, output int p);
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while ((w ? fmStrobe : tickEvent) !== 1'h1 && n < 300);
        p = 0;
        do begin @(negedge clk); p++; end while ((w ? fmStrobe : tickEvent) !== 1'h1 && p < 300);
        @(posedge clk);
    endtask
    // One-cycle pulse: 0 crystal failure, 1 quality pass, 2 full-stop wake; ends at the negedge after
    task automatic pulse_in(input int w);
        crystalFail <= (w == 0);
        qualityOk <= (w == 1);
        fullStopWake <= (w == 2);
        @(posedge clk);
        crystalFail <= 1'h0;
        qualityOk <= 1'h0;
        fullStopWake <= 1'h0;
        @(negedge clk);
    endtask
    task automatic t_bus;
        rd(8'h18);
        chk(d, 32'h01);
        rd(8'h1C);
        chk(d, 32'h00);
        rd(8'h00);
        chk(r, 2'h2);
        wr(8'h00, 8'hFF);
        chk(r, 2'h2);
    endtask
    task automatic t_amp;
        for (int k = 0; k < 4; k++) begin
            wr(8'h18, {2'h0, k[1:0], 4'h1});
            chk(freqModAmplitude, k);
        end
        per(1'h1, c);
        chk(c, 16);
        wr(8'h18, 8'h30);
        rd(8'h18);
        chk(d, 32'h31);
    endtask
    task automatic t_pll;
        wr(8'h20, 8'h80);
        chk(pllClockSelect, 1'h0);
        pllLock <= 1'h1;
        wr(8'h20, 8'h80);
        chk(pllClockSelect, 1'h1);
        wr(8'h18, 8'h11);
        chk(freqModAmplitude, 2'h3);
    endtask
    task automatic t_tick;
        for (int k = 0; k < 5; k++) begin
            wr(8'h1C, tc[k]);
            rd(8'h1C);
            chk(d, tc[k]);
            per(1'h0, c);
            chk(c, tp[k]);
        end
        wr(8'h1C, 8'h12);
        pseudoStop <= 1'h1;
        @(negedge clk);
        chk(tickRun, 1'h0);
        chk(watchdogRun, 1'h0);
        chk(watchdogInit, 1'h0);
        per(1'h0, c);
        chk(c, 300);
        wr(8'h18, 8'h37);
        chk(tickRun, 1'h1);
        chk(watchdogRun, 1'h1);
        per(1'h0, c);
        chk(c, 6);
        pseudoStop <= 1'h0;
        wr(8'h20, 8'h83);
        waitMode <= 1'h1;
        @(negedge clk);
        chk(tickRun, 1'h0);
        chk(watchdogInit, 1'h1);
        @(posedge clk);
        waitMode <= 1'h0;
    endtask
    task automatic t_fail;
        pulse_in(0);
        chk(selfClockActive, 1'h1);
        chk(clockMonitorReset, 1'h0);
        chk(pllClockSelect, 1'h0);
        @(posedge clk);
        specialMode <= 1'h1;
        wr(8'h18, 8'h10);
        rd(8'h18);
        chk(d[0], 1'h1);
        wr(8'h24, 8'h02);
        pulse_in(1);
        chk(selfClockActive, 1'h0);
        @(posedge clk);
        rd(8'h24);
        chk(d[1:0], 2'h2);
    endtask
    task automatic t_fast;
        wr(8'h18, 8'h09);
        wr(8'h24, 8'h02);
        pulse_in(2);
        chk(selfClockActive, 1'h1);
        chk(oscEnable, 1'h0);
        chk(clockMonitorEnable, 1'h0);
        @(posedge clk);
        rd(8'h24);
        chk(d[1:0], 2'h1);
        wr(8'h18, 8'h01);
        @(negedge clk);
        chk(oscEnable, 1'h1);
        chk(qualityCheckRun, 1'h1);
        @(posedge clk);
        pulse_in(1);
        chk(selfClockActive, 1'h0);
        @(posedge clk);
        rd(8'h24);
        chk(d[1:0], 2'h2);
    endtask
    task automatic t_nofall;
        wr(8'h18, 8'h08);
        rd(8'h18);
        chk(d, 32'h08);
        pulse_in(2);
        chk(selfClockActive, 1'h0);
        @(posedge clk);
        pulse_in(0);
        chk(clockMonitorReset, 1'h1);
        chk(selfClockActive, 1'h0);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        t_bus();
        t_amp();
        t_pll();
        t_tick();
        t_fail();
        t_fast();
        t_nofall();
        results();
    end
endmodule // tb_top
